// >>> eep_array.sv
// Data EEPROM cell array with registered read port
`timescale 1ns/1ps
module eep_array (
  // Clock
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Commit port
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read port
  input wire logic [7:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_r [256];
  logic [7:0] rdata_r;

  // Cell writes during commit
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // Registered read data
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= mem_r[i_raddr];
    end
  end

  assign o_rdata = rdata_r;
endmodule : eep_array

// >>> eep_cpu_model.sv
// CPU-side APB master model that issues the row programmer's bus transfers
`timescale 1ns/1ps
module eep_cpu_model (
  // Clock and answer
  input wire logic i_clk,
  input wire logic i_pready,
  // Request
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [11:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb
);
  // Idle bus from time zero
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
    o_pstrb = 4'h0;
  end
  // One transfer: setup, then access held until ready is seen
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    o_pstrb <= 4'h1;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1) @(posedge i_clk);
    // Released address and data lines show the inverse so stale values never look valid
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer
endmodule : eep_cpu_model

// >>> eep_pkg.sv
// Constants and types shared by the data EEPROM row programmer
// How it works
// - Read mode serves EEPROM reads from the array
// - Write mode stores bytes into 32 latches
// - Setting program start commits all latched bytes
// - Row comes from the last latched write
// - Program start reads 1 until cycle ends
// - Cycle end also clears latch access bit
// - A control write clears latch access only while program start clear
// - Rewriting a latch stores the bitwise AND
// - Latches clear at cycle end and access fall
// - Latched bytes are never readable
// - Control bits 7:2 read zero, ignore writes
// - Control register at 0020h, resets to 00h
package eep_pkg;
  // Register byte addresses on the bus
  localparam logic [11:0] EEP_CTRL_OFF = 12'h020;
  localparam logic [11:0] EEP_STAT_OFF = 12'h024;
  localparam logic [11:0] EEP_MASK_OFF = 12'h028;
  localparam logic [11:0] EEP_ARR_BASE = 12'h400;
  localparam logic [11:0] EEP_ARR_LAST = 12'h7fc;
  // Control register fields and reset value
  localparam int EEP_GO_BIT = 0;
  localparam int EEP_LATCH_BIT = 1;
  localparam logic [7:0] EEP_CTRL_RST = 8'h00;
  // Status and mask layout
  localparam int EEP_DONE_BIT = 0;
  localparam logic EEP_STAT_RST = 1'b0;
  localparam logic EEP_MASK_RST = 1'b0;
  // Array geometry
  localparam int EEP_NUM_LATCH = 32;
  localparam int EEP_ADDR_W = 8;
  localparam logic [4:0] EEP_LAST_COL = 5'h1f;
  // Default programming time in clock cycles
  localparam int EEP_PROG_CYCLES_DEF = 64;
  // Programming sequence states, Gray coded
  typedef enum logic [1:0] {
    EEP_IDLE = 2'b00,
    EEP_WAIT = 2'b01,
    EEP_COMMIT = 2'b11
  } eep_state_t;
endpackage : eep_pkg

// >>> eep_row_programmer.sv
// Data EEPROM row programmer with APB register and array access
`timescale 1ns/1ps
module eep_row_programmer
  import eep_pkg::*;
#(
  parameter int PROG_CYCLES = EEP_PROG_CYCLES_DEF
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Interrupt
  output logic O_IRQ
);
  // Control state
  eep_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [4:0] col_r, col_nxt;
  logic [2:0] row_r, row_nxt;
  logic latch_r, latch_nxt;
  logic go_r, go_nxt;
  logic done_r, done_nxt;
  logic mask_r, mask_nxt;
  logic [7:0] lat_data_r [EEP_NUM_LATCH];
  logic [7:0] lat_data_nxt [EEP_NUM_LATCH];
  logic [EEP_NUM_LATCH-1:0] lat_vld_r, lat_vld_nxt;
  // Bus decode
  logic acc, wr, rd, is_ctrl, is_stat, is_mask, is_arr, mapped;
  logic [7:0] idx;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic done_evt;

  localparam logic [15:0] LAST_CNT = 16'(PROG_CYCLES - 1);

  // Address decode; every access finishes with no wait state
  always_comb begin
    acc = I_PSEL && I_PENABLE;
    wr = acc && I_PWRITE;
    rd = acc && !I_PWRITE;
    idx = I_PADDR[9:2];
    is_ctrl = 1'b0;
    is_stat = 1'b0;
    is_mask = 1'b0;
    is_arr = 1'b0;
    if (I_PADDR == EEP_CTRL_OFF) begin
      is_ctrl = 1'b1;
    end else if (I_PADDR == EEP_STAT_OFF) begin
      is_stat = 1'b1;
    end else if (I_PADDR == EEP_MASK_OFF) begin
      is_mask = 1'b1;
    end else if (I_PADDR >= EEP_ARR_BASE && I_PADDR <= EEP_ARR_LAST
                 && I_PADDR[1:0] == 2'b00) begin
      is_arr = 1'b1;
    end
    mapped = is_ctrl || is_stat || is_mask || is_arr;
  end

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc && !mapped;

  // Read mux; array data is the registered cell word, never a latch
  always_comb begin
    O_PRDATA = 32'h0000_0000;
    if (rd && is_ctrl) begin
      O_PRDATA = {30'h0000_0000, latch_r, go_r};
    end else if (rd && is_stat) begin
      O_PRDATA = {31'h0000_0000, done_r};
    end else if (rd && is_mask) begin
      O_PRDATA = {31'h0000_0000, mask_r};
    end else if (rd && is_arr) begin
      O_PRDATA = {24'h00_0000, mem_rdata};
    end
  end

  // Next state of control, latches and programming sequence
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    col_nxt = col_r;
    row_nxt = row_r;
    latch_nxt = latch_r;
    go_nxt = go_r;
    mask_nxt = mask_r;
    lat_data_nxt = lat_data_r;
    lat_vld_nxt = lat_vld_r;
    mem_we = 1'b0;
    done_evt = 1'b0;
    // Control register write
    if (wr && is_ctrl && I_PSTRB[0]) begin
      if (I_PWDATA[EEP_GO_BIT] && !go_r) begin
        go_nxt = 1'b1;
        state_nxt = EEP_WAIT;
        cnt_nxt = 16'h0000;
      end else if (!I_PWDATA[EEP_GO_BIT] && go_r) begin
        go_nxt = 1'b0; // Early clear aborts, cells left as they are
        state_nxt = EEP_IDLE;
      end
      if (I_PWDATA[EEP_LATCH_BIT]) begin
        latch_nxt = 1'b1;
      end else if (!go_r) begin
        latch_nxt = 1'b0;
      end
    end
    if (wr && is_mask && I_PSTRB[0]) begin
      mask_nxt = I_PWDATA[EEP_DONE_BIT];
    end
    // Store into the latch picked by the low address bits
    if (wr && is_arr && I_PSTRB[0] && latch_r && !go_r) begin
      if (lat_vld_r[idx[4:0]]) begin
        lat_data_nxt[idx[4:0]] = lat_data_r[idx[4:0]] & I_PWDATA[7:0];
      end else begin
        lat_data_nxt[idx[4:0]] = I_PWDATA[7:0];
      end
      lat_vld_nxt[idx[4:0]] = 1'b1;
      row_nxt = idx[7:5];
    end
    // Programming sequence
    case (state_r)
      EEP_WAIT: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r == LAST_CNT) begin
          state_nxt = EEP_COMMIT;
          col_nxt = 5'h00;
        end
      end
      EEP_COMMIT: begin
        mem_we = lat_vld_r[col_r];
        col_nxt = col_r + 5'h01;
        if (col_r == EEP_LAST_COL) begin
          state_nxt = EEP_IDLE;
          go_nxt = 1'b0;
          latch_nxt = 1'b0;
          done_evt = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // Latches empty at cycle end and on every fall of latch access
    if (latch_r && !latch_nxt) begin
      lat_vld_nxt = '0;
      for (int i = 0; i < EEP_NUM_LATCH; i++) begin
        lat_data_nxt[i] = 8'hff;
      end
    end
  end

  // Sticky done flag, a new event wins over a write-one clear
  always_comb begin
    done_nxt = done_r;
    if (wr && is_stat && I_PSTRB[0] && I_PWDATA[EEP_DONE_BIT]) begin
      done_nxt = 1'b0;
    end
    if (done_evt) begin
      done_nxt = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r <= EEP_IDLE;
      cnt_r <= 16'h0000;
      col_r <= 5'h00;
      row_r <= 3'h0;
      latch_r <= EEP_CTRL_RST[EEP_LATCH_BIT];
      go_r <= EEP_CTRL_RST[EEP_GO_BIT];
      done_r <= EEP_STAT_RST;
      mask_r <= EEP_MASK_RST;
      lat_vld_r <= '0;
      for (int i = 0; i < EEP_NUM_LATCH; i++) begin
        lat_data_r[i] <= 8'hff;
      end
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      col_r <= col_nxt;
      row_r <= row_nxt;
      latch_r <= latch_nxt;
      go_r <= go_nxt;
      done_r <= done_nxt;
      mask_r <= mask_nxt;
      lat_vld_r <= lat_vld_nxt;
      lat_data_r <= lat_data_nxt;
    end
  end

  assign O_IRQ = done_r && mask_r;

  // Cell array; read address taken from the setup phase
  eep_array u_array (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_we(mem_we),
    .i_waddr({row_r, col_r}),
    .i_wdata(lat_data_r[col_r]),
    .i_raddr(idx),
    .o_rdata(mem_rdata)
  );

  // Checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  logic [7:0] old_lat;
  assign old_lat = lat_data_r[idx[4:0]];

  // Cycles spent with program start set, for the length check
  localparam logic [15:0] BUSY_CNT = 16'(PROG_CYCLES + EEP_NUM_LATCH);
  logic [15:0] busy_cnt_r, busy_cnt_nxt;
  always_comb begin
    busy_cnt_nxt = 16'h0000;
    if (go_r) begin
      busy_cnt_nxt = busy_cnt_r + 16'h0001;
    end
  end
  // Busy counter register
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      busy_cnt_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  sequence s_commit_last;
    state_r == EEP_COMMIT && col_r == EEP_LAST_COL;
  endsequence

  sequence s_back_idle;
    state_r == EEP_IDLE && !go_r && !latch_r && lat_vld_r == '0;
  endsequence

  // Reset state and bus read path
  chk_reset_clear: assert property (
    !$past(I_ARST_N) |-> !go_r && !latch_r && !done_r && !mask_r && lat_vld_r == '0)
    else $error("control state not cleared by reset");
  chk_read_array: assert property (
    I_PSEL && !I_PENABLE && !I_PWRITE && is_arr ##1 rd && is_arr
    |-> O_PRDATA[7:0] == $past(u_array.mem_r[idx]) && O_PRDATA[31:8] == 24'h00_0000)
    else $error("array read data does not come from the cells");

  // Latch store and commit
  chk_latch_store: assert property (
    wr && is_arr && I_PSTRB[0] && latch_r && !go_r && !lat_vld_r[idx[4:0]]
    |=> lat_vld_r[$past(idx[4:0])] && lat_data_r[$past(idx[4:0])] == $past(I_PWDATA[7:0]))
    else $error("write in latch mode not stored");
  chk_commit_only_valid: assert property (
    mem_we |-> state_r == EEP_COMMIT && lat_vld_r[col_r])
    else $error("cell written without a valid latch");
  chk_row_from_last: assert property (
    wr && is_arr && I_PSTRB[0] && latch_r && !go_r |=> row_r == $past(idx[7:5]))
    else $error("row not taken from last latched write");

  // Control bits and end of cycle
  chk_go_while_busy: assert property (
    state_r != EEP_IDLE |-> go_r)
    else $error("program start low during a cycle");
  chk_end_returns: assert property (
    s_commit_last |=> s_back_idle ##1 !go_r)
    else $error("cycle end did not clear control and latches");
  chk_latch_hold: assert property (
    wr && is_ctrl && I_PSTRB[0] && go_r && latch_r && I_PWDATA[EEP_GO_BIT]
    && !(state_r == EEP_COMMIT && col_r == EEP_LAST_COL)
    |=> latch_r)
    else $error("latch access cleared while programming");
  chk_latch_and: assert property (
    wr && is_arr && I_PSTRB[0] && latch_r && !go_r && lat_vld_r[idx[4:0]]
    |=> lat_data_r[$past(idx[4:0])] == ($past(old_lat) & $past(I_PWDATA[7:0])))
    else $error("rewritten latch is not the AND of both bytes");
  chk_latch_clear: assert property (
    $fell(latch_r) |-> lat_vld_r == '0)
    else $error("latches survive a fall of latch access");
  chk_ctrl_reserved: assert property (
    rd && is_ctrl |-> O_PRDATA[31:2] == 30'h0000_0000)
    else $error("reserved control bits read nonzero");
  chk_wait_length: assert property (
    state_r == EEP_WAIT && cnt_r == LAST_CNT && go_r |=> state_r == EEP_COMMIT && col_r == 5'h00)
    else $error("programming wait length wrong");

  // Status, interrupt and cycle length
  chk_irq_level: assert property (
    done_evt && mask_nxt |=> O_IRQ)
    else $error("interrupt missing after completion");
  chk_done_sticky: assert property (
    done_r && !(wr && is_stat && I_PSTRB[0] && I_PWDATA[EEP_DONE_BIT]) |=> done_r)
    else $error("done flag lost without a clear");
  chk_no_store_busy: assert property (
    wr && is_arr && go_r && !(state_r == EEP_COMMIT && col_r == EEP_LAST_COL)
    |=> $stable(lat_vld_r) && $stable(row_r))
    else $error("array write stored while programming");
  chk_busy_length: assert property (
    $fell(go_r) && !$past(wr && is_ctrl && I_PSTRB[0] && !I_PWDATA[EEP_GO_BIT])
    |-> busy_cnt_r == BUSY_CNT)
    else $error("program start high for the wrong number of cycles");
endmodule : eep_row_programmer

// >>> eep_row_programmer_tb.sv
// Self-checking bench for the data EEPROM row programmer
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module eep_row_programmer_tb;
  import eep_pkg::*;
  localparam int PCYC = 4;
  typedef struct packed {logic [31:0] d; logic e;} eep_note_t;
  logic I_CLK = 1'b0;
  logic I_ARST_N = 1'b0;
  logic psel, pen, pwr, rdy, serr, irq;
  logic [11:0] padr;
  logic [31:0] pwd, prd;
  logic [3:0] pstrb;
  int err_total = 0;
  int check_count = 0;
  int seed = 81207;
  int cyc = 0;
  eep_note_t notes[$];
  eep_note_t nt;
  logic [7:0] img [256];
  logic [7:0] v;
  eep_row_programmer #(.PROG_CYCLES(PCYC)) i_eep_row_programmer (.I_CLK(I_CLK),
    .I_ARST_N(I_ARST_N), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
    .I_PWDATA(pwd), .I_PSTRB(pstrb), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(serr),
    .O_IRQ(irq));
  eep_cpu_model i_eep_cpu_model (.i_clk(I_CLK), .i_pready(rdy), .o_psel(psel),
    .o_penable(pen), .o_pwrite(pwr), .o_paddr(padr), .o_pwdata(pwd), .o_pstrb(pstrb));
  // Clock generation
  initial begin
    forever #10 I_CLK = ~I_CLK;
  end
  // Byte address of array cell n
  function automatic logic [11:0] ca(input int n);
    return EEP_ARR_BASE + 12'(4 * n);
  endfunction : ca
  task wr(input logic [11:0] a, input logic [7:0] d);
    i_eep_cpu_model.xfer(1'b1, a, {24'h0, d});
  endtask : wr
  // Note the expected answer, then issue the read
  task rd(input logic [11:0] a, input logic [31:0] e, input logic er);
    notes.push_back('{e, er});
    i_eep_cpu_model.xfer(1'b0, a, 32'h0);
  endtask : rd
  // Start a cycle, try to drop the latch bit, wait it out, check done is set
  task prog();
    wr(EEP_CTRL_OFF, 8'h03);
    wr(EEP_CTRL_OFF, 8'h01);
    rd(EEP_CTRL_OFF, 32'h3, 1'b0);
    wr(ca(33), 8'h00);
    repeat (PCYC + 40) @(posedge I_CLK);
    rd(EEP_CTRL_OFF, 32'h0, 1'b0);
    rd(EEP_STAT_OFF, 32'h1, 1'b0);
  endtask : prog
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Compare each read answer with the oldest note
  always @(negedge I_CLK) begin
    if (psel && pen && !pwr) begin
      if (notes.size() == 0) begin
        `CHK(1'b0, 1'b1)
      end else begin
        nt = notes.pop_front();
        `CHK(rdy, 1'b1)
        `CHK(prd, nt.d)
        `CHK(serr, nt.e)
      end
    end
  end
  // Hang guard
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    rd(EEP_CTRL_OFF, 32'h0, 1'b0);
    rd(EEP_STAT_OFF, 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    wr(EEP_CTRL_OFF, 8'hfe);
    rd(EEP_CTRL_OFF, 32'h2, 1'b0);
    // Fill row 1 in one row only, then over-write one latch
    for (int c = 0; c < 32; c++) begin
      v = 8'($random(seed));
      img[32 + c] = v;
      wr(ca(32 + c), v);
    end
    v = 8'($random(seed));
    img[35] = img[35] & v;
    wr(ca(35), v);
    prog();
    #1 `CHK(irq, 1'b0)
    wr(EEP_MASK_OFF, 8'h01);
    #1 `CHK(irq, 1'b1)
    wr(EEP_STAT_OFF, 8'h01);
    #1 `CHK(irq, 1'b0)
    for (int c = 32; c < 64; c++) rd(ca(c), {24'h0, img[c]}, 1'b0);
    $display("test row fill done");
    // Single latch in row 5 must not touch row 1
    wr(EEP_CTRL_OFF, 8'h02);
    v = 8'($random(seed));
    wr(ca(160), v);
    prog();
    wr(EEP_STAT_OFF, 8'h01);
    rd(ca(160), {24'h0, v}, 1'b0);
    rd(ca(32), {24'h0, img[32]}, 1'b0);
    $display("test row select done");
    // Latched byte is hidden and dropped when write mode falls
    wr(EEP_CTRL_OFF, 8'h02);
    wr(ca(39), 8'h00);
    rd(ca(39), {24'h0, img[39]}, 1'b0);
    wr(EEP_CTRL_OFF, 8'h00);
    rd(EEP_CTRL_OFF, 32'h0, 1'b0);
    wr(EEP_CTRL_OFF, 8'h02);
    v = 8'($random(seed));
    wr(ca(40), v);
    prog();
    rd(ca(39), {24'h0, img[39]}, 1'b0);
    rd(ca(40), {24'h0, v}, 1'b0);
    $display("test latch clear done");
    repeat (4) @(posedge I_CLK);
    report_and_stop();
  end
endmodule : eep_row_programmer_tb
